/* File: rtl/alarm_detail_regs.vh */
// Purpose: offsets, field positions and counts for the alarm detail and warning registers
// Assumes: included by every design file of the block
// Notes: offsets are parameter numbers of the register port
`ifndef ALARM_DETAIL_REGS_VH
`define ALARM_DETAIL_REGS_VH

// ************************************************************
// register offsets
// ************************************************************
`define ADR_SELECTOR 8'h19
`define ADR_READOUT 8'h1a
`define ADR_WARNING 8'h1d

// ************************************************************
// selector fields and reset value
// ************************************************************
`define SEL_ITEM_MSB 7
`define SEL_ITEM_LSB 0
`define SEL_ENTRY_MSB 15
`define SEL_ENTRY_LSB 8
`define SEL_RESET 16'h0000
`define ITEM_LAST 8'h0b
`define ENTRY_LAST 8'h07

// ************************************************************
// information item codes
// ************************************************************
`define ITEM_CODE 4'h0
`define ITEM_DATE 4'h1
`define ITEM_TIME 4'h2
`define ITEM_POWER_ON 4'h3
`define ITEM_STATUS 4'h4
`define ITEM_CURRENT 4'h5
`define ITEM_SPEED 4'h6
`define ITEM_POSITION 4'h7
`define ITEM_VOLTAGE 4'h8
`define ITEM_TEMP 4'h9
`define ITEM_OVERLOAD 4'ha
`define ITEM_CMD_OVERLOAD 4'hb

// ************************************************************
// history store geometry
// ************************************************************
`define HIST_ENTRIES 4'h8
`define ITEM_COUNT 4'hc
`define MEM_AW 7
`define MEM_DW 32

// ************************************************************
// warning word fields
// ************************************************************
`define WARN_SUPPLY_LOW 0
`define WARN_BATTERY_LOW 1
`define WARN_FROZEN_LSB 3
`define WARN_FROZEN_MSB 11
`define WARN_RESET 16'h0000

`endif

/* File: rtl/alarm_history_mem.v */
// Purpose: storage of the captured alarm details, one word per item
// Assumes: single clock, one write and one read port
// Notes: read data come from a register one cycle after the address
`include "alarm_detail_regs.vh"

module alarm_history_mem (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_we,
  input wire [`MEM_AW-1:0] i_waddr,
  input wire [`MEM_DW-1:0] i_wdata,
  input wire [`MEM_AW-1:0] i_raddr,
  output reg [`MEM_DW-1:0] o_rdata
);

  reg [`MEM_DW-1:0] mem [0:(1<<`MEM_AW)-1];

  always @(posedge i_mclk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // contents are not reset; unwritten slots are masked by the entry count and the item range upstream
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 32'h00000000;
    end
    else
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

/* File: rtl/alarm_detail_warning_regs.v */
// Purpose: alarm history detail selector, detail readout and warning status word
// Assumes: all alarm and warning inputs come from logic on i_mclk
// Notes: the readout follows a selector write two cycles later
`include "alarm_detail_regs.vh"

module alarm_detail_warning_regs (
  input wire i_mclk,
  input wire i_arst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_alarm_raise,
  input wire i_alarm_reset,
  input wire [7:0] i_alarm_code,
  input wire [15:0] i_date_bcd,
  input wire [15:0] i_time_bcd,
  input wire [31:0] i_power_on_min,
  input wire [31:0] i_servo_status,
  input wire [31:0] i_fb_current,
  input wire [31:0] i_fb_speed,
  input wire [31:0] i_fb_position,
  input wire [31:0] i_supply_voltage,
  input wire [31:0] i_temperature,
  input wire [31:0] i_overload,
  input wire [31:0] i_cmd_overload,
  input wire [11:0] i_warn_cond,
  output reg [15:0] o_warning_status,
  output reg o_capture_busy
);

  // ************************************************************
  // reset release
  // ************************************************************
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // ************************************************************
  // selector register
  // ************************************************************
  reg [15:0] sel_reg;
  wire [7:0] sel_item;
  wire [7:0] sel_entry;

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_reg <= `SEL_RESET;
    end
    else if (i_wr && (i_addr == `ADR_SELECTOR))
    begin
      // out-of-range codes are kept so software can read back what it wrote
      sel_reg <= i_wdata[15:0];
    end
  end

  assign sel_item = sel_reg[`SEL_ITEM_MSB:`SEL_ITEM_LSB];
  assign sel_entry = sel_reg[`SEL_ENTRY_MSB:`SEL_ENTRY_LSB];

  // ************************************************************
  // snapshot capture
  // ************************************************************
  // every figure is latched in the raise cycle so the slow item-by-item
  // write into the store cannot mix values from different moments
  reg [383:0] snap_reg;
  reg busy_reg;
  reg [3:0] wr_item_reg;
  reg [2:0] head_reg;
  reg [3:0] count_reg;
  wire [2:0] wr_slot;
  wire capture_start;
  wire capture_last;
  wire [31:0] wr_word;

  assign capture_start = i_alarm_raise && !busy_reg;
  assign capture_last = busy_reg && (wr_item_reg == `ITEM_CMD_OVERLOAD);
  assign wr_slot = head_reg + 3'h1;

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snap_reg <= 384'h0;
    end
    else if (capture_start)
    begin
      snap_reg <= {i_cmd_overload,
                   i_overload,
                   i_temperature,
                   i_supply_voltage,
                   i_fb_position,
                   i_fb_speed,
                   i_fb_current,
                   i_servo_status,
                   i_power_on_min,
                   16'h0000, i_time_bcd,
                   16'h0000, i_date_bcd,
                   24'h000000, i_alarm_code};
    end
  end

  assign wr_word = snap_reg[wr_item_reg * 32 +: 32];

  // a raise while a capture is still being written is dropped
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      wr_item_reg <= 4'h0;
      head_reg <= 3'h7;
      count_reg <= 4'h0;
    end
    else if (capture_start)
    begin
      busy_reg <= 1'b1;
      wr_item_reg <= `ITEM_CODE;
    end
    else if (capture_last)
    begin
      busy_reg <= 1'b0;
      wr_item_reg <= 4'h0;
      // the new entry becomes the latest only when complete
      head_reg <= wr_slot;
      if (count_reg != `HIST_ENTRIES)
      begin
        count_reg <= count_reg + 4'h1;
      end
    end
    else if (busy_reg)
    begin
      wr_item_reg <= wr_item_reg + 4'h1;
    end
  end

  // ************************************************************
  // history store and readout
  // ************************************************************
  wire [2:0] rd_slot;
  wire item_ok;
  wire entry_ok;
  wire [31:0] mem_rdata;
  reg valid_dly_reg;
  reg [31:0] readout_reg;

  // limitation: with eight entries held, a capture reuses the slot of entry 07,
  // so entry 07 read while a capture is written may mix old and new words
  assign rd_slot = head_reg - sel_entry[2:0];
  assign item_ok = (sel_item <= `ITEM_LAST);
  assign entry_ok = (sel_entry <= `ENTRY_LAST) && ({1'b0, sel_entry[2:0]} < count_reg);

  alarm_history_mem u_mem (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_we(busy_reg),
    .i_waddr({wr_slot, wr_item_reg}),
    .i_wdata(wr_word),
    .i_raddr({rd_slot, sel_item[3:0]}),
    .o_rdata(mem_rdata)
  );

  // the valid flag is delayed to line up with the registered memory read
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_dly_reg <= 1'b0;
      readout_reg <= 32'h00000000;
    end
    else
    begin
      valid_dly_reg <= item_ok && entry_ok;
      readout_reg <= valid_dly_reg ? mem_rdata : 32'h00000000;
    end
  end

  // ************************************************************
  // warning status word
  // ************************************************************
  reg frozen_reg;
  reg [8:0] held_reg;
  reg [15:0] warn_next;
  wire [8:0] warn_live;

  assign warn_live = i_warn_cond[`WARN_FROZEN_MSB:`WARN_FROZEN_LSB];

  // a raise in the same cycle as an alarm reset wins; a frozen word keeps its earlier held bits
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frozen_reg <= 1'b0;
      held_reg <= 9'h000;
    end
    else if (i_alarm_raise && !frozen_reg)
    begin
      frozen_reg <= 1'b1;
      held_reg <= i_warn_cond[`WARN_FROZEN_MSB:`WARN_FROZEN_LSB];
    end
    else if (i_alarm_reset && !i_alarm_raise)
    begin
      frozen_reg <= 1'b0;
      held_reg <= 9'h000;
    end
  end

  // reserved bits 2 and 12 to 15 keep their reset value of zero
  // the reset cycle shows the held bits as zero, one cycle before they go live
  always @*
  begin
    warn_next = `WARN_RESET;
    warn_next[`WARN_SUPPLY_LOW] = i_warn_cond[`WARN_SUPPLY_LOW];
    warn_next[`WARN_BATTERY_LOW] = i_warn_cond[`WARN_BATTERY_LOW];
    if (i_alarm_reset && !i_alarm_raise)
    begin
      warn_next[`WARN_FROZEN_MSB:`WARN_FROZEN_LSB] = 9'h000;
    end
    else if (frozen_reg)
    begin
      warn_next[`WARN_FROZEN_MSB:`WARN_FROZEN_LSB] = held_reg;
    end
    else
    begin
      warn_next[`WARN_FROZEN_MSB:`WARN_FROZEN_LSB] = warn_live;
    end
  end

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_warning_status <= `WARN_RESET;
    end
    else
    begin
      o_warning_status <= warn_next;
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  reg [31:0] rdata_next;

  // the data slot is one cycle wide; every other cycle drives zero
  always @*
  begin
    rdata_next = 32'h00000000;
    if (i_rd)
    begin
      case (i_addr)
        `ADR_SELECTOR: rdata_next = {16'h0000, sel_reg};
        `ADR_READOUT: rdata_next = readout_reg;
        `ADR_WARNING: rdata_next = {16'h0000, o_warning_status};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rdata <= 32'h00000000;
      o_capture_busy <= 1'b0;
    end
    else
    begin
      o_capture_busy <= busy_reg;
      o_rdata <= rdata_next;
    end
  end

endmodule

/* File: testbench/alarm_detail_warning_regs_properties.sv */
// Purpose: port-level checks of the alarm detail and warning registers
// Assumes: one clock; alarm pulses come from i_mclk logic
// Notes: freeze state is rebuilt here from the alarm pulses
module alarm_detail_props (
  input wire i_mclk,
  input wire i_arst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire i_alarm_raise,
  input wire i_alarm_reset,
  input wire [11:0] i_warn_cond,
  input wire [15:0] o_warning_status,
  input wire o_capture_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  reg frz_reg;

  // ********
  // freeze tracking
  // ********
  // raise wins over a reset in the same cycle
  always @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      frz_reg <= 1'b0;
    else if (i_alarm_raise)
      frz_reg <= 1'b1;
    else if (i_alarm_reset)
      frz_reg <= 1'b0;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  a_reserved_zero: assert property (
    {o_warning_status[15:12], o_warning_status[2]} == 5'h00) else $error("reserved bit set");
  a_mid_live: assert property (
    !frz_reg && !i_alarm_raise && !i_alarm_reset
    |=> o_warning_status[11:3] == $past(i_warn_cond[11:3])) else $error("bits not live");
  a_freeze_take: assert property (
    i_alarm_raise && !frz_reg
    |=> o_warning_status[11:3] == $past(i_warn_cond[11:3])) else $error("bad freeze");
  a_frozen_hold: assert property (
    frz_reg && !i_alarm_reset |=> $stable(o_warning_status[11:3])) else $error("held bits moved");
  a_reset_clears: assert property (
    frz_reg && i_alarm_reset && !i_alarm_raise
    |=> o_warning_status[11:3] == 9'h000) else $error("held bits not cleared");
  a_sel_readback: assert property (
    i_wr && i_addr == 8'h19 ##1 i_rd && i_addr == 8'h19
    |=> o_rdata == {16'h0000, $past(i_wdata[15:0], 2)}) else $error("selector readback");
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0) else $error("read data outside slot");
  a_busy_span: assert property (
    $rose(o_capture_busy) |-> o_capture_busy[*8] ##1 o_capture_busy[*4] ##1 !o_capture_busy)
    else $error("capture length");

  c_alarm: cover property (i_alarm_raise && !o_capture_busy);
  c_reset_frozen: cover property (frz_reg && i_alarm_reset);
  c_readout: cover property (i_rd && i_addr == 8'h1a ##1 o_rdata != 32'h0);
endmodule

bind alarm_detail_warning_regs alarm_detail_props u_props (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_alarm_raise(i_alarm_raise), .i_alarm_reset(i_alarm_reset),
  .i_warn_cond(i_warn_cond), .o_warning_status(o_warning_status),
  .o_capture_busy(o_capture_busy));

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the alarm detail and warning registers
// Assumes: reset held 6 cycles, fixed seed
// Notes: a read is judged at the edge after it is taken
`include "alarm_detail_regs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg i_mclk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, rd_q = 0;
  reg i_alarm_raise = 0, i_alarm_reset = 0;
  reg [7:0] i_addr = 0;
  reg [11:0] i_warn_cond = 0, wa, wb;
  reg [31:0] i_wdata = 0, rexp = 0, exp_q = 0, r;
  reg [31:0] cap [0:11];
  reg [31:0] hist [0:95];
  wire [31:0] o_rdata;
  wire [15:0] o_warning_status;
  wire o_capture_busy;
  integer seed = 32'hea37, failures = 0, cmp_count = 0, nhist = 0, e, j, k, n;

  alarm_detail_warning_regs u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_alarm_raise(i_alarm_raise), .i_alarm_reset(i_alarm_reset), .i_alarm_code(cap[0][7:0]),
    .i_date_bcd(cap[1][15:0]), .i_time_bcd(cap[2][15:0]), .i_power_on_min(cap[3]),
    .i_servo_status(cap[4]), .i_fb_current(cap[5]), .i_fb_speed(cap[6]),
    .i_fb_position(cap[7]), .i_supply_voltage(cap[8]), .i_temperature(cap[9]),
    .i_overload(cap[10]), .i_cmd_overload(cap[11]), .i_warn_cond(i_warn_cond),
    .o_warning_status(o_warning_status), .o_capture_busy(o_capture_busy));

  always #5 i_mclk = ~i_mclk;

  // ********
  // tasks
  // ********
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // sampled before this edge's updates land, so the answer slot is seen race-free
  always @(posedge i_mclk)
  begin
    if (rd_q)
      chk(o_rdata, exp_q);
    rd_q <= i_rd;
    exp_q <= rexp;
  end

  // w=1 writes d, w=0 reads and expects d
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      i_addr <= a;
      i_wdata <= d;
      rexp <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_mclk);
    end
  endtask

  task idle;
    begin
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(posedge i_mclk);
    end
  endtask

  function [31:0] expv(input integer en, input integer it);
    expv = (en < nhist && it < 12) ? hist[en * 12 + it] : 32'h0;
  endfunction

  task sel(input [15:0] s);
    begin
      bus(1, `ADR_SELECTOR, {16'h0, s});
      bus(0, `ADR_SELECTOR, {16'h0, s});
      // the readout settles two edges after the selector write, so it is read at the third
      idle;
      bus(0, `ADR_READOUT, expv(s[15:8], s[7:0]));
    end
  endtask

  task scan;
    begin
      for (e = 0; e < 9; e = e + 1)
        for (j = 0; j < 13; j = j + 1)
          sel({e[7:0], j[7:0]});
      idle;
    end
  endtask

  task alarm(input [11:0] c, input [11:0] d);
    begin
      for (n = 0; n < 12; n = n + 1)
        cap[n] <= $random(seed);
      i_warn_cond <= c;
      i_alarm_raise <= 1'b1;
      @(posedge i_mclk);
      i_alarm_raise <= 1'b0;
      i_warn_cond <= d;
      for (n = 95; n > 11; n = n - 1)
        hist[n] = hist[n - 12];
      for (n = 0; n < 12; n = n + 1)
      begin
        hist[n] = n == 0 ? cap[n] & 32'hff : n < 3 ? cap[n] & 32'hffff : cap[n];
        cap[n] <= ~cap[n];
      end
      nhist = nhist < 8 ? nhist + 1 : 8;
      @(posedge i_mclk);
      @(negedge i_mclk);
      chk(o_warning_status, {4'h0, c & 12'hff8 | d & 12'h003});
      for (n = 0; n < 30 && (n < 3 || o_capture_busy === 1'b1); n = n + 1)
        @(negedge i_mclk);
      chk(o_warning_status, {4'h0, c & 12'hff8 | d & 12'h003});
      @(posedge i_mclk);
      i_alarm_reset <= 1'b1;
      @(posedge i_mclk);
      i_alarm_reset <= 1'b0;
      @(negedge i_mclk);
      chk(o_warning_status, {14'h0, d[1:0]});
      @(negedge i_mclk);
      chk(o_warning_status, {4'h0, d & 12'hffb});
      @(posedge i_mclk);
    end
  endtask

  initial
  begin
    for (n = 0; n < 12; n = n + 1)
      cap[n] = 32'h0;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    bus(0, `ADR_SELECTOR, `SEL_RESET);
    bus(0, 8'h00, 32'h0);
    bus(1, `ADR_READOUT, 32'hffffffff);
    bus(0, `ADR_READOUT, 32'h0);
    bus(1, `ADR_WARNING, 32'hffffffff);
    bus(0, `ADR_WARNING, 32'h0);
    idle;
    $display("test bus done");
    for (k = 0; k < 5; k = k + 1)
    begin
      wa = k == 0 ? 12'hfff : $random(seed);
      i_warn_cond <= wa;
      @(posedge i_mclk);
      bus(0, `ADR_WARNING, {20'h0, wa & 12'hffb});
    end
    idle;
    $display("test warning done");
    for (k = 0; k < 9; k = k + 1)
    begin
      wa = $random(seed);
      wb = $random(seed);
      alarm(wa, wb);
      if (k == 1)
        scan;
    end
    scan;
    for (k = 0; k < 20; k = k + 1)
    begin
      r = $random(seed);
      sel(k[0] ? r[15:0] : r[15:0] & 16'h070f);
    end
    idle;
    $display("test history done");
    results;
  end

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    failures = failures + 1;
    results;
  end
endmodule
